// [hdl/trg_control.sv]
// timer control/mode registers, run gating, overflow and external interrupt flags
// assumes the core drives sfr strobes on sys_clk_i and acks vectoring for one cycle
`timescale 1ns/1ps
// What this block does
// - each external interrupt input is caught either on a falling edge or as a low level.
// - a type select of 0 means level triggered and 1 means edge triggered.
// - with timer 1 gate clear, timer 1 counts whenever its run bit is 1.
// - with timer 1 gate set, timer 1 counts only while run is 1 and input 1 is high.
// - timer 0 runs when its run bit is set and its gate is 0 or input 0 is high.
// - a 13-bit wrap from all ones to zero sets the timer 0 overflow flag.
// - in split mode the upper byte runs on the timer 1 run bit and sets timer 1 overflow.
// - setting a run bit leaves the count untouched and counting resumes from it.
module trg_control (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire trg_pkg::trg_sfr_req_s sfr_req_i,
  input wire trg_pkg::trg_vector_ack_s vector_ack_i,
  input wire logic external_interrupt_0_input_i,
  input wire logic external_interrupt_1_input_i,
  output logic [7:0] sfr_rdata_o,
  output logic [7:0] timer_control_reg_o,
  output logic [7:0] timer_mode_reg_o,
  output logic [15:0] timer0_count_o,
  output trg_pkg::trg_enables_s enables_o,
  output logic timer0_irq_o,
  output logic timer1_irq_o,
  output logic extint0_irq_o,
  output logic extint1_irq_o
);
  logic [7:0] timer_control_reg;
  logic [7:0] timer_mode_reg;
  logic [7:0] timer0_high_byte;
  logic [7:0] timer0_low_byte;
  logic [7:0] sfr_rdata;
  logic [1:0] pin_raw;
  logic [1:0] pin_lvl;
  logic [1:0] pin_prev;
  logic wr_ctrl;
  logic wr_mode;
  logic rd_ctrl;
  logic rd_mode;
  logic [7:0] next_timer_control_reg;
  logic [7:0] next_timer_mode_reg;
  logic [7:0] next_timer0_high_byte;
  logic [7:0] next_timer0_low_byte;
  logic [7:0] next_sfr_rdata;
  logic external_interrupt_0_input_lvl;
  logic external_interrupt_1_input_lvl;
  logic timer0_enable;
  logic timer0_high_enable;
  logic timer1_enable;
  logic split_mode;
  logic low_ovf;
  logic high_ovf;
  logic ext0_event;
  logic ext1_event;

  assign pin_raw = {external_interrupt_1_input_i, external_interrupt_0_input_i};

  // pins are asynchronous, so the first stage is never read; the second gives the level, the third the edge history
  for (genvar i = 0; i < 2; i++) begin : g_pin
    logic meta;
    logic lvl;
    logic prev;
    logic next_meta;
    logic next_lvl;
    logic next_prev;
    always_comb begin
      next_meta = pin_raw[i];
      next_lvl = meta;
      next_prev = lvl;
    end
    // pins idle high, so a reset value of 1 keeps a false edge from following reset
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        meta <= 1'b1;
        lvl <= 1'b1;
        prev <= 1'b1;
      end else begin
        meta <= next_meta;
        lvl <= next_lvl;
        prev <= next_prev;
      end
    end
    assign pin_lvl[i] = lvl;
    assign pin_prev[i] = prev;
  end
  assign external_interrupt_0_input_lvl = pin_lvl[0];
  assign external_interrupt_1_input_lvl = pin_lvl[1];

  function automatic logic ext_event(input logic edge_sel, input logic lvl, input logic prev);
    // edge mode fires once per falling edge; level mode fires every low cycle
    ext_event = edge_sel ? (prev & ~lvl) : ~lvl;
  endfunction

  // one strobe plus one address match; used by every register access
  function automatic logic sfr_hit(input logic strobe, input logic [7:0] addr,
    input logic [7:0] target);
    sfr_hit = strobe && addr == target;
  endfunction

  localparam int TM_MODE0_HI = trg_pkg::TM_MODE0_LO + 1;

  always_comb begin
    wr_ctrl = sfr_hit(sfr_req_i.wr, sfr_req_i.addr, trg_pkg::TIMER_CONTROL_ADDR);
    wr_mode = sfr_hit(sfr_req_i.wr, sfr_req_i.addr, trg_pkg::TIMER_MODE_ADDR);
    rd_ctrl = sfr_hit(sfr_req_i.rd, sfr_req_i.addr, trg_pkg::TIMER_CONTROL_ADDR);
    rd_mode = sfr_hit(sfr_req_i.rd, sfr_req_i.addr, trg_pkg::TIMER_MODE_ADDR);
  end

  // enables are combinational so the gate pin acts within the synchroniser delay only
  always_comb begin
    split_mode = timer_mode_reg[TM_MODE0_HI:trg_pkg::TM_MODE0_LO] == trg_pkg::MODE_SPLIT;
    timer0_enable = timer_control_reg[trg_pkg::TC_TR0]
      & (~timer_mode_reg[trg_pkg::TM_TIMER0_GATE_CONTROL] | external_interrupt_0_input_lvl);
    timer1_enable = timer_control_reg[trg_pkg::TC_TR1]
      & (~timer_mode_reg[trg_pkg::TM_TIMER1_GATE_CONTROL] | external_interrupt_1_input_lvl);
    timer0_high_enable = split_mode & timer_control_reg[trg_pkg::TC_TR1];
    ext0_event = ext_event(timer_control_reg[trg_pkg::TC_IT0], external_interrupt_0_input_lvl, pin_prev[0]);
    ext1_event = ext_event(timer_control_reg[trg_pkg::TC_IT1], external_interrupt_1_input_lvl, pin_prev[1]);
  end

  // timer 0 counter: 13-bit in mode 0, split bytes in mode 3, 16-bit otherwise
  // limitation: mode 2 reload is not modelled, it wraps like mode 1
  // in mode 0 the low byte bits 7:5 hold whatever they had and are not counted
  always_comb begin
    next_timer0_high_byte = timer0_high_byte;
    next_timer0_low_byte = timer0_low_byte;
    low_ovf = 1'b0;
    high_ovf = 1'b0;
    // the run bit only gates counting; nothing here loads the count on its write
    if (split_mode) begin
      if (timer0_enable) begin
        low_ovf = timer0_low_byte == trg_pkg::BYTE_MAX;
        next_timer0_low_byte = timer0_low_byte + 8'h01;
      end
      if (timer0_high_enable) begin
        high_ovf = timer0_high_byte == trg_pkg::BYTE_MAX;
        next_timer0_high_byte = timer0_high_byte + 8'h01;
      end
    end else if (timer0_enable) begin
      if (timer_mode_reg[TM_MODE0_HI:trg_pkg::TM_MODE0_LO] == trg_pkg::MODE_13BIT) begin
        low_ovf = {timer0_high_byte, timer0_low_byte[4:0]} == trg_pkg::COUNT13_MAX;
        {next_timer0_high_byte, next_timer0_low_byte[4:0]} =
          {timer0_high_byte, timer0_low_byte[4:0]} + 13'h0001;
      end else begin
        low_ovf = {timer0_high_byte, timer0_low_byte} == {trg_pkg::BYTE_MAX, trg_pkg::BYTE_MAX};
        {next_timer0_high_byte, next_timer0_low_byte} =
          {timer0_high_byte, timer0_low_byte} + 16'h0001;
      end
    end
  end

  // register writes first, then hardware sets win over any clear in the same cycle
  always_comb begin
    next_timer_control_reg = timer_control_reg;
    next_timer_mode_reg = timer_mode_reg;
    if (wr_ctrl) begin
      next_timer_control_reg = sfr_req_i.wdata;
    end else if (wr_mode) begin
      next_timer_mode_reg = sfr_req_i.wdata;
    end
    // acks clear first so a flag raised in the same cycle is never lost
    if (vector_ack_i.timer0_ack) next_timer_control_reg[trg_pkg::TC_TF0] = 1'b0;
    if (vector_ack_i.timer1_ack) next_timer_control_reg[trg_pkg::TC_TF1] = 1'b0;
    if (vector_ack_i.extint0_ack) next_timer_control_reg[trg_pkg::TC_IE0] = 1'b0;
    if (vector_ack_i.extint1_ack) next_timer_control_reg[trg_pkg::TC_IE1] = 1'b0;
    if (low_ovf) next_timer_control_reg[trg_pkg::TC_TF0] = 1'b1;
    if (high_ovf) next_timer_control_reg[trg_pkg::TC_TF1] = 1'b1;
    if (ext0_event) next_timer_control_reg[trg_pkg::TC_IE0] = 1'b1;
    if (ext1_event) next_timer_control_reg[trg_pkg::TC_IE1] = 1'b1;
  end

  // read data stands one cycle and falls back to zero, unmapped reads give zero
  always_comb begin
    if (rd_ctrl) begin
      next_sfr_rdata = timer_control_reg;
    end else if (rd_mode) begin
      next_sfr_rdata = timer_mode_reg;
    end else begin
      next_sfr_rdata = 8'h00;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      timer_control_reg <= trg_pkg::TIMER_CONTROL_RESET;
      timer_mode_reg <= trg_pkg::TIMER_MODE_RESET;
      timer0_high_byte <= trg_pkg::COUNT_RESET[15:8];
      timer0_low_byte <= trg_pkg::COUNT_RESET[7:0];
      sfr_rdata <= 8'h00;
    end else begin
      timer_control_reg <= next_timer_control_reg;
      timer_mode_reg <= next_timer_mode_reg;
      timer0_high_byte <= next_timer0_high_byte;
      timer0_low_byte <= next_timer0_low_byte;
      sfr_rdata <= next_sfr_rdata;
    end
  end

  assign sfr_rdata_o = sfr_rdata;
  assign timer_control_reg_o = timer_control_reg;
  assign timer_mode_reg_o = timer_mode_reg;
  assign timer0_count_o = {timer0_high_byte, timer0_low_byte};
  assign enables_o = '{timer0_enable: timer0_enable, timer0_high_enable: timer0_high_enable,
                       timer1_enable: timer1_enable};
  assign timer0_irq_o = timer_control_reg[trg_pkg::TC_TF0];
  assign timer1_irq_o = timer_control_reg[trg_pkg::TC_TF1];
  assign extint0_irq_o = timer_control_reg[trg_pkg::TC_IE0];
  assign extint1_irq_o = timer_control_reg[trg_pkg::TC_IE1];
endmodule

// [hdl/trg_pkg.sv]
// package for the timer run-gate and external interrupt control block
// assumes a single 25 MHz system clock and an sfr-style byte port from the core
package trg_pkg;
  localparam logic [7:0] TIMER_CONTROL_ADDR = 8'h88;
  localparam logic [7:0] TIMER_MODE_ADDR = 8'h89;
  localparam logic [7:0] TIMER_CONTROL_RESET = 8'h00;
  localparam logic [7:0] TIMER_MODE_RESET = 8'h00;
  // timer_control bit positions
  localparam int TC_TF1 = 7;
  localparam int TC_TR1 = 6;
  localparam int TC_TF0 = 5;
  localparam int TC_TR0 = 4;
  localparam int TC_IE1 = 3;
  localparam int TC_IT1 = 2;
  localparam int TC_IE0 = 1;
  localparam int TC_IT0 = 0;
  // timer_mode bit positions
  localparam int TM_TIMER1_GATE_CONTROL = 7;
  localparam int TM_TIMER0_GATE_CONTROL = 3;
  localparam int TM_MODE0_LO = 0;
  localparam logic [1:0] MODE_13BIT = 2'h0;
  localparam logic [1:0] MODE_SPLIT = 2'h3;
  localparam logic [12:0] COUNT13_MAX = 13'h1fff;
  localparam logic [7:0] BYTE_MAX = 8'hff;
  localparam logic [15:0] COUNT_RESET = 16'h0000;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } trg_sfr_req_s;

  typedef struct packed {
    logic timer0_ack;
    logic timer1_ack;
    logic extint0_ack;
    logic extint1_ack;
  } trg_vector_ack_s;

  typedef struct packed {
    logic timer0_enable;
    logic timer0_high_enable;
    logic timer1_enable;
  } trg_enables_s;
endpackage

// [bench/trg_control_assertions.sv]
// checker for trg_control: run gating, overflow and interrupt flags
// assumes it is bound to trg_control and watches only its ports
`timescale 1ns/1ps
module trg_control_assertions (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire trg_pkg::trg_vector_ack_s vector_ack_i,
  input wire logic external_interrupt_0_input_i,
  input wire logic external_interrupt_1_input_i,
  input wire logic [7:0] timer_control_reg_o,
  input wire logic [7:0] timer_mode_reg_o,
  input wire logic [15:0] timer0_count_o,
  input wire trg_pkg::trg_enables_s enables_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  logic [7:0] tc;
  logic [7:0] tm;
  assign tc = timer_control_reg_o;
  assign tm = timer_mode_reg_o;
  // four samples low covers the two-flop synchroniser
  sequence s_pin1_low; (!external_interrupt_1_input_i)[*4]; endsequence
  sequence s_fall0; tc[0] ##0 $fell(external_interrupt_0_input_i); endsequence
  t0_run_a: assert property (tc[4] && !tm[3] |-> enables_o.timer0_enable)
    else $error("timer 0 not enabled");
  t0_stop_a: assert property (!tc[4] |-> !enables_o.timer0_enable)
    else $error("timer 0 enabled while stopped");
  t1_free_a: assert property (tc[6] && !tm[7] && tm[1:0] != 2'h3 |-> enables_o.timer1_enable)
    else $error("timer 1 not enabled");
  t1_gated_a: assert property (s_pin1_low ##0 tm[7] |-> !enables_o.timer1_enable)
    else $error("gated timer 1 runs with pin low");
  count_kept_a: assert property ($rose(tc[4]) |-> timer0_count_o[7:0] == $past(timer0_count_o[7:0]))
    else $error("count changed on start");
  wrap13_a: assert property (tm[1:0] == 2'h0 && enables_o.timer0_enable
    && timer0_count_o[15:8] == 8'hff && timer0_count_o[4:0] == 5'h1f |=> tc[5])
    else $error("13-bit wrap left flag clear");
  split_run_a: assert property (tm[1:0] == 2'h3 |-> enables_o.timer0_high_enable == tc[6])
    else $error("upper byte enable wrong");
  split_ovf_a: assert property (tm[1:0] == 2'h3 && enables_o.timer0_high_enable
    && timer0_count_o[15:8] == 8'hff |=> tc[7])
    else $error("upper byte wrap left flag clear");
  ack_clear_a: assert property (vector_ack_i.timer0_ack && !enables_o.timer0_enable |=> !tc[5])
    else $error("flag kept after vectoring");
  edge_set_a: assert property (s_fall0 |-> ##[2:4] tc[1])
    else $error("falling edge missed");
  level_set_a: assert property ((!external_interrupt_1_input_i && !tc[2])[*4] |=> tc[3])
    else $error("low level missed");
endmodule
bind trg_control trg_control_assertions chk (.*);

// [bench/trg_core_model.sv]
// core stand-in: vectors to every pending interrupt while en_i is high
// assumes irq levels ordered timer0, timer1, extint0, extint1
`timescale 1ns/1ps
module trg_core_model (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic en_i,
  input wire logic [3:0] irq_i,
  output trg_pkg::trg_vector_ack_s ack_o
);
  // the flag drops a cycle after the ack, so skip a cycle between acks
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ack_o <= '0;
    end else begin
      ack_o <= irq_i & {4{en_i}} & ~ack_o;
    end
  end
endmodule

// [bench/trg_control_bench.sv]
// self-checking bench for trg_control with a core stand-in
// assumes trg_pkg compiled first and the checker bound to trg_control
`timescale 1ns/1ps
module trg_control_bench;
  logic clk = 1'b0, rst_n = 1'b0, ack_en = 1'b0, p0 = 1'b1, p1 = 1'b1;
  logic i0, i1, e0, e1;
  logic [7:0] rdata, tc, tm;
  logic [15:0] cnt, c;
  trg_pkg::trg_sfr_req_s req = '0;
  trg_pkg::trg_vector_ack_s ack;
  trg_pkg::trg_enables_s en;
  int errors = 0, checks = 0, n;
  // rows: mode, control, pins {1,0}, expected enables {timer0, timer1}
  logic [19:0] rows [6] = '{20'h00503, 20'h88500, 20'h8850f, 20'h88506, 20'h08108, 20'h0000c};
  always #20 clk = ~clk;
  trg_control uut (.sys_clk_i(clk), .reset_n_i(rst_n), .sfr_req_i(req), .vector_ack_i(ack),
    .external_interrupt_0_input_i(p0), .external_interrupt_1_input_i(p1), .sfr_rdata_o(rdata),
    .timer_control_reg_o(tc), .timer_mode_reg_o(tm), .timer0_count_o(cnt), .enables_o(en),
    .timer0_irq_o(i0), .timer1_irq_o(i1), .extint0_irq_o(e0), .extint1_irq_o(e1));
  trg_core_model core (.sys_clk_i(clk), .reset_n_i(rst_n), .en_i(ack_en),
    .irq_i({i0, i1, e0, e1}), .ack_o(ack));
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 req = '{1'b1, 1'b0, a, d};
    @(posedge clk);
    #1 req = '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    #1 req = '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk);
    #1 req = '0;
    chk(rdata, e);
  endtask
  task automatic end_sim;
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #1200000;
    errors++;
    end_sim();
  end
  initial begin
    repeat (3) @(posedge clk);
    #1 rst_n = 1'b1;
    chk({tc, tm}, 16'h0000);
    rd(8'h8a, 8'h00);
    for (n = 0; n < 6; n++) begin
      wr(8'h89, rows[n][19:12]);
      wr(8'h88, rows[n][11:4]);
      {p1, p0} = rows[n][3:2];
      repeat (4) @(posedge clk);
      #1 chk({en.timer0_enable, en.timer1_enable}, rows[n][1:0]);
    end
    // free-running 13-bit count, so the wrap needs up to 8192 cycles
    wr(8'h88, 8'h10);
    for (n = 0; n < 9000 && !i0; n++) #40;
    chk(tc[5], 1'b1);
    wr(8'h88, 8'h20);
    c = cnt;
    ack_en = 1'b1;
    #120 chk(tc[5], 1'b0);
    ack_en = 1'b0;
    wr(8'h88, 8'h10);
    chk(cnt[7:0], c[7:0]);
    #40 chk(cnt[4:0], c[4:0] + 5'h01);
    wr(8'h88, 8'h00);
    rd(8'h88, 8'h00);
    wr(8'h89, 8'h03);
    rd(8'h89, 8'h03);
    wr(8'h88, 8'h40);
    chk({en.timer0_high_enable, en.timer0_enable}, 2'b10);
    for (n = 0; n < 300 && !i1; n++) #40;
    chk(tc[7], 1'b1);
    wr(8'h89, 8'h00);
    wr(8'h88, 8'h01);
    p0 = 1'b0;
    #200 chk(tc[1], 1'b1);
    wr(8'h88, 8'h01);
    #200 chk(tc[1], 1'b0);
    wr(8'h88, 8'h00);
    #200 chk(tc[1], 1'b1);
    chk(e0, 1'b1);
    p0 = 1'b1;
    end_sim();
  end
endmodule
